// *** hw/psms_pkg.sv ***
/*
 * Package of the port mode sequencer: register offsets, register layouts,
 * auto-mode threshold tables, timing counts and the carrier types.
 * Assumes a 250 MHz clock and four ports behind one register block.
 */
`default_nettype none

package psms_pkg;

	// ********************************************************************
	// sizes, offsets and timing
	// ********************************************************************
	localparam int NPORTS = 4;
	localparam int CUR_W  = 12;
	localparam int CNT_W  = 25;

	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_ENABLE  = 8'h08;
	localparam logic [7:0] OFS_CMD     = 8'h0C;
	localparam logic [7:0] OFS_STATUS0 = 8'h10;
	localparam logic [7:0] OFS_STEP    = 8'h04;

	localparam int HOLD_TIME_MS = 100;
	localparam int CLK_FREQ_KHZ = 250000;
	localparam int HOLD_CYCLES  = HOLD_TIME_MS * CLK_FREQ_KHZ;

	// smallest change of the first channel's current that shows a single signature
	localparam logic [CUR_W-1:0] CC_DELTA_MIN = 12'h040;

	// ********************************************************************
	// auto-mode thresholds, power in half watts, indexed by class 0..8
	// ********************************************************************
	localparam logic [7:0] SS_P2_HW [0:8] = '{8'h1F, 8'h08, 8'h0E, 8'h1F, 8'h3C,
		8'h40, 8'h4F, 8'h5B, 8'h6C};
	localparam logic [7:0] SS_P4_HW [0:8] = '{8'h1F, 8'h08, 8'h0E, 8'h1F, 8'h3C,
		8'h5A, 8'h78, 8'h96, 8'hB4};
	// dual signature: classes outside 1..5 fall back to the class 1 figure
	localparam logic [7:0] DS_P2_HW [0:8] = '{8'h08, 8'h08, 8'h0E, 8'h1F, 8'h3C,
		8'h5A, 8'h08, 8'h08, 8'h08};
	localparam logic [7:0] DS_P4_HW     = 8'hB4;
	localparam logic [7:0] TYPE1_CAP_HW = 8'h1F;
	localparam logic [1:0] ILIM_CODE [0:8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h1, 2'h1, 2'h2, 2'h2};
	localparam logic [1:0] ILIM_DUAL = 2'h3;

	// ********************************************************************
	// enumerations
	// ********************************************************************
	typedef enum logic [1:0] {
		MODE_SHUT   = 2'b00,
		MODE_MANUAL = 2'b01,
		MODE_SEMI   = 2'b10,
		MODE_AUTO   = 2'b11
	} psms_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_DETECT  = 3'b001,
		ST_CC1     = 3'b010,
		ST_CC2     = 3'b011,
		ST_CLASS   = 3'b100,
		ST_HOLD    = 3'b101,
		ST_POWERED = 3'b110
	} psms_state_t;

	typedef enum logic [1:0] {
		SIG_UNKNOWN = 2'b00,
		SIG_SINGLE  = 2'b01,
		SIG_DUAL    = 2'b10,
		SIG_INVALID = 2'b11
	} psms_sig_t;

	// ********************************************************************
	// carriers and register layouts
	// ********************************************************************
	typedef struct packed {
		logic [7:0] p2_hw;
		logic [7:0] p4_hw;
		logic [1:0] ilim;
		logic       disc_low;
	} psms_lim_t;

	typedef struct packed {
		logic det_go;
		logic meas_go;
		logic meas_force2;
		logic cls_go;
	} psms_fe_req_t;

	typedef struct packed {
		logic             det_done;
		logic             det_valid;
		logic             meas_done;
		logic [CUR_W-1:0] meas_cur;
		logic             cls_done;
		logic [3:0]       cls_val;
		logic             pd_change;
		logic [1:0]       fault;
		logic [1:0]       unplug;
	} psms_fe_rsp_t;

	typedef struct packed {
		logic [29:0] rsv;
		logic        strap_auto;
		logic        reset_all;
	} psms_ctrl_t;

	typedef struct packed {
		logic [23:0]                  rsv;
		psms_mode_t [NPORTS-1:0]      mode;
	} psms_mode_reg_t;

	typedef struct packed {
		logic [11:0]       rsv;
		logic [NPORTS-1:0] legacy;
		logic [NPORTS-1:0] four_pair;
		logic [NPORTS-1:0] disc_en;
		logic [NPORTS-1:0] cls_en;
		logic [NPORTS-1:0] det_en;
	} psms_enable_t;

	typedef struct packed {
		logic [15:0]       rsv;
		logic [NPORTS-1:0] power_off;
		logic [NPORTS-1:0] power_on;
		logic [NPORTS-1:0] det_cls;
		logic [NPORTS-1:0] detect;
	} psms_cmd_t;

	typedef struct packed {
		logic [7:0]  p4_hw;
		logic [7:0]  p2_hw;
		logic        rsv;
		psms_state_t st;
		logic        start_fault;
		logic [1:0]  pwr;
		logic        cls_known;
		logic [3:0]  cls;
		psms_sig_t   sig;
		logic        det_known;
		logic        det_valid;
	} psms_status_t;

	typedef struct packed {
		psms_state_t      st;
		logic [1:0]       pwr;
		logic             det_known;
		logic             det_valid;
		psms_sig_t        sig;
		logic             cls_known;
		logic [3:0]       cls;
		logic             with_cls;
		logic             cc_bad;
		logic             start_fault;
		psms_lim_t        lim;
		logic [CNT_W-1:0] cnt;
		logic [CUR_W-1:0] i1;
		psms_fe_req_t     req;
	} psms_port_t;

	// hreadyout sits in the lowest bit so the reset value is a plain constant
	typedef struct packed {
		psms_port_t [NPORTS-1:0] port;
		logic                    strap_taken;
		logic                    strap_auto;
		logic                    soft_rst;
		psms_mode_reg_t          mode;
		psms_enable_t            en;
		logic                    dp_valid;
		logic                    dp_write;
		logic [7:0]              dp_addr;
		logic [31:0]             hrdata;
		logic                    hresp;
		logic                    hreadyout;
	} psms_top_t;

	localparam psms_top_t TOP_RST = psms_top_t'({{($bits(psms_top_t) - 1){1'b0}}, 1'b1});

endpackage

`default_nettype wire

// *** hw/psms_port_mode_sequencer.sv ***
/*
 * Per-port operating-mode sequencer of a four-port PoE power controller,
 * with its AHB-Lite register slave. Runs detection, connection check and
 * classification through a measurement front end and switches channel power.
 * Assumes front-end inputs synchronous to clk, one-cycle done strobes.
 */
// Notes on behaviour
// - mode field per port: 11 auto, 10 semi-auto, 01 manual, 00 shutdown; writable
// - strapped auto: detect, classify, assign limits, power, drop on unplug, enabled
// - manual: idle until commanded, then one detect or detect+class, status reported
// - manual: host may apply or remove power at any time
// - semi-auto: repeated detect/class, results reported, power only on host command
// - auto: like semi-auto, powers on alone after detect and class succeed
// - auto loads two-pair, four-pair power and four-pair current limits from class
// - shutdown: no detection, classification, power-up or threshold assignment
// - any fault removes channel power; host removal accepted at any time
// - unplug event removes power when disconnect detection is enabled
// - reset by power-up, reset pin, or reset-all bit; strap sampled then
// - later strap changes ignored until next reset
// - spare strap pin has no effect
// - single signature class 0-4 or type 1 capped: equal limits, 7.0mA threshold
// - single signature class 5-8: split limits, 3.5mA threshold
// - dual signature class 1-5: two-pair per class, four-pair 90 W, 3.5mA
// - auto single signature class 0-4 uses pair-count setting
// - connection check: two current readings, second with channel two forced
// - attach or removal during connection check gives invalid result
// - connection check only in four-pair operation, skipped for legacy type 1
// - semi-auto waits at least 100ms before repeating detection
// - power-on command needs a valid detection, otherwise start fault
`default_nettype none

module psms_port_mode_sequencer #(
	parameter int HOLD_CYC = psms_pkg::HOLD_CYCLES
) (
	// clock and reset
	input  wire logic                                           clk,
	input  wire logic                                           rstn,
	// straps
	input  wire logic                                           mode_strap_pin,
	input  wire logic                                           spare_strap_pin,
	// AHB-Lite slave
	input  wire logic                                           hsel,
	input  wire logic [31:0]                                    haddr,
	input  wire logic [1:0]                                     htrans,
	input  wire logic                                           hwrite,
	input  wire logic [2:0]                                     hsize,
	input  wire logic [31:0]                                    hwdata,
	input  wire logic                                           hready,
	output logic      [31:0]                                    hrdata,
	output logic                                                hreadyout,
	output logic                                                hresp,
	// measurement front end
	output var        psms_pkg::psms_fe_req_t [psms_pkg::NPORTS-1:0] fe_req,
	input  wire       psms_pkg::psms_fe_rsp_t [psms_pkg::NPORTS-1:0] fe_rsp,
	// power switches and limits
	output logic      [2*psms_pkg::NPORTS-1:0]                  power_en,
	output var        psms_pkg::psms_lim_t [psms_pkg::NPORTS-1:0] port_lim
);
	import psms_pkg::*;

	// ********************************************************************
	// state and lookups
	// ********************************************************************
	psms_top_t                  r_r;
	psms_top_t                  r_nxt;
	psms_lim_t [NPORTS-1:0]     lim_lu;

	psms_cmd_t                  cmd;
	psms_mode_reg_t             mode_new;
	psms_mode_reg_t             mode_wr;
	psms_enable_t               en_new;
	logic [NPORTS-1:0]          restart;
	logic [NPORTS-1:0]          sf_clr;
	psms_port_t                 p;
	psms_fe_rsp_t               f;
	psms_mode_t                 m;
	logic                       det_end;
	logic                       pass_end;
	logic                       sf_set;
	logic [1:0]                 chan;
	logic [CUR_W-1:0]           dlt;
	logic                       wr;
	logic                       addr_ok;

	function automatic psms_lim_t thr_lookup(input psms_sig_t s, input logic [3:0] c,
			input logic t1);
		psms_lim_t  l;
		logic [3:0] k;
		k = (c > 4'h8) ? 4'h0 : c;
		l.p2_hw    = SS_P2_HW[k];
		l.p4_hw    = SS_P4_HW[k];
		l.ilim     = ILIM_CODE[k];
		l.disc_low = (k >= 4'h5);
		if (s == SIG_DUAL) begin
			l.p2_hw    = DS_P2_HW[k];
			l.p4_hw    = DS_P4_HW;
			l.ilim     = ILIM_DUAL;
			l.disc_low = 1'b1;
		end else if (t1 && k >= 4'h4) begin
			l.p2_hw    = TYPE1_CAP_HW;
			l.p4_hw    = TYPE1_CAP_HW;
			l.ilim     = ILIM_CODE[0];
			l.disc_low = 1'b0;
		end
		return l;
	endfunction

	function automatic logic [31:0] rd_word(input psms_top_t s, input logic [7:0] a);
		logic [31:0]  d;
		psms_status_t st;
		psms_ctrl_t   c;
		d = 32'h0000_0000;
		c = '0;
		c.strap_auto = s.strap_auto;
		if (a == OFS_CTRL)
			d = c;
		if (a == OFS_MODE)
			d = s.mode;
		if (a == OFS_ENABLE)
			d = s.en;
		for (int k = 0; k < NPORTS; k++) begin
			st             = '0;
			st.det_valid   = s.port[k].det_valid;
			st.det_known   = s.port[k].det_known;
			st.sig         = s.port[k].sig;
			st.cls         = s.port[k].cls;
			st.cls_known   = s.port[k].cls_known;
			st.pwr         = s.port[k].pwr;
			st.start_fault = s.port[k].start_fault;
			st.st          = s.port[k].st;
			st.p2_hw       = s.port[k].lim.p2_hw;
			st.p4_hw       = s.port[k].lim.p4_hw;
			if (a == OFS_STATUS0 + 8'(k * 4))
				d = st;
		end
		return d;
	endfunction

	// ********************************************************************
	// per-port lookup and outputs
	// ********************************************************************
	for (genvar g = 0; g < NPORTS; g++) begin : g_port
		// class is taken from the strobe cycle so power and limits land together
		assign lim_lu[g]            = thr_lookup(r_r.port[g].sig, fe_rsp[g].cls_val,
			r_r.en.legacy[g]);
		assign fe_req[g]            = r_r.port[g].req;
		assign power_en[2*g +: 2]   = r_r.port[g].pwr;
		assign port_lim[g]          = r_r.port[g].lim;
	end

	assign hrdata    = r_r.hrdata;
	assign hreadyout = r_r.hreadyout;
	assign hresp     = r_r.hresp;

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		r_nxt    = r_r;
		p        = '0;
		f        = '0;
		m        = MODE_SHUT;
		det_end  = 1'b0;
		pass_end = 1'b0;
		sf_set   = 1'b0;
		chan     = 2'b00;
		dlt      = '0;
		sf_clr   = '0;
		cmd      = '0;
		wr       = r_r.dp_valid && r_r.dp_write;

		// bus: address phase, read data prepared a cycle early; always OKAY
		addr_ok        = hsel && htrans[1] && hready;
		r_nxt.dp_valid = addr_ok;
		r_nxt.dp_write = addr_ok && hwrite;
		r_nxt.dp_addr  = addr_ok ? haddr[7:0] : r_r.dp_addr;
		r_nxt.hresp    = 1'b0;
		r_nxt.hreadyout = 1'b1;
		if (addr_ok && !hwrite)
			r_nxt.hrdata = rd_word(r_r, haddr[7:0]);

		// bus: data phase writes
		mode_new = r_r.mode;
		en_new   = r_r.en;
		mode_wr  = psms_mode_reg_t'(hwdata);
		if (wr && r_r.dp_addr == OFS_MODE)
			mode_new.mode = mode_wr.mode;
		if (wr && r_r.dp_addr == OFS_ENABLE) begin
			en_new     = psms_enable_t'(hwdata);
			en_new.rsv = '0;
		end
		if (wr && r_r.dp_addr == OFS_CMD)
			cmd = psms_cmd_t'(hwdata);
		if (wr && r_r.dp_addr == OFS_CTRL)
			r_nxt.soft_rst = hwdata[0];
		for (int k = 0; k < NPORTS; k++) begin
			if (wr && r_r.dp_addr == OFS_STATUS0 + 8'(k * 4))
				sf_clr[k] = hwdata[11];
		end

		// strap is caught once, on the first edge after any reset
		if (!r_r.strap_taken) begin
			r_nxt.strap_taken = 1'b1;
			r_nxt.strap_auto  = mode_strap_pin;
			if (mode_strap_pin) begin
				for (int k = 0; k < NPORTS; k++)
					mode_new.mode[k] = MODE_AUTO;
				en_new.det_en = '1;
				en_new.cls_en = '1;
				en_new.disc_en = '1;
			end
		end
		for (int k = 0; k < NPORTS; k++)
			restart[k] = (mode_new.mode[k] != r_r.mode.mode[k]);
		r_nxt.mode = mode_new;
		r_nxt.en   = en_new;

		// ports
		for (int i = 0; i < NPORTS; i++) begin
			p        = r_r.port[i];
			f        = fe_rsp[i];
			m        = mode_new.mode[i];
			det_end  = 1'b0;
			pass_end = 1'b0;
			sf_set   = 1'b0;
			p.req    = '0;
			chan     = (r_r.en.four_pair[i] || p.sig == SIG_DUAL ||
				(p.cls_known && p.cls > 4'h4)) ? 2'b11 : 2'b01;

			if (cmd.power_on[i] && m != MODE_SHUT && p.pwr == 2'b00) begin
				if (p.det_known && p.det_valid) begin
					p.pwr = chan;
					p.st  = ST_POWERED;
				end else begin
					sf_set = 1'b1;
				end
			end

			unique case (p.st)
				ST_IDLE: begin
					if ((m == MODE_MANUAL && (cmd.detect[i] || cmd.det_cls[i])) ||
							((m == MODE_SEMI || m == MODE_AUTO) && r_r.en.det_en[i])) begin
						p.st         = ST_DETECT;
						p.req.det_go = 1'b1;
						p.det_known  = 1'b0;
						p.cls_known  = 1'b0;
						p.sig        = SIG_UNKNOWN;
						p.with_cls   = (m == MODE_MANUAL) ? cmd.det_cls[i]
							: r_r.en.cls_en[i];
					end
				end
				ST_DETECT: begin
					if (f.det_done) begin
						p.det_known = 1'b1;
						p.det_valid = f.det_valid;
						if (f.det_valid && r_r.en.four_pair[i] && !r_r.en.legacy[i]) begin
							p.st          = ST_CC1;
							p.req.meas_go = 1'b1;
							p.cc_bad      = 1'b0;
						end else begin
							p.sig   = f.det_valid ? SIG_SINGLE : SIG_INVALID;
							det_end = 1'b1;
						end
					end
				end
				ST_CC1: begin
					if (f.pd_change)
						p.cc_bad = 1'b1;
					if (f.meas_done) begin
						p.i1              = f.meas_cur;
						p.st              = ST_CC2;
						p.req.meas_go     = 1'b1;
						p.req.meas_force2 = 1'b1;
					end
				end
				ST_CC2: begin
					if (f.pd_change)
						p.cc_bad = 1'b1;
					if (f.meas_done) begin
						// a single signature makes the forced current pull channel one
						dlt = (f.meas_cur >= p.i1) ? f.meas_cur - p.i1 : p.i1 - f.meas_cur;
						if (p.cc_bad)
							p.sig = SIG_INVALID;
						else
							p.sig = (dlt >= CC_DELTA_MIN) ? SIG_SINGLE : SIG_DUAL;
						det_end = 1'b1;
					end
				end
				ST_CLASS: begin
					if (f.cls_done) begin
						p.cls       = f.cls_val;
						p.cls_known = 1'b1;
						pass_end    = 1'b1;
					end
				end
				ST_HOLD: begin
					if (p.cnt == '0)
						p.st = ST_IDLE;
					else
						p.cnt = p.cnt - 1'b1;
				end
				ST_POWERED: begin
				end
				default: begin
					p.st = ST_IDLE;
				end
			endcase

			if (det_end) begin
				if (p.det_valid && p.sig != SIG_INVALID && p.with_cls) begin
					p.st         = ST_CLASS;
					p.req.cls_go = 1'b1;
				end else begin
					pass_end = 1'b1;
				end
			end
			if (pass_end) begin
				if (m == MODE_MANUAL) begin
					p.st = ST_IDLE;
				end else if (m == MODE_AUTO && p.det_valid && p.sig != SIG_INVALID &&
						p.cls_known) begin
					p.lim = lim_lu[i];
					p.pwr = (r_r.en.four_pair[i] || p.sig == SIG_DUAL ||
						p.cls > 4'h4) ? 2'b11 : 2'b01;
					p.st  = ST_POWERED;
				end else begin
					p.st  = ST_HOLD;
					p.cnt = CNT_W'(HOLD_CYC - 1);
				end
			end

			// removal applies in every mode and state
			p.pwr = p.pwr & ~f.fault;
			if (r_r.en.disc_en[i])
				p.pwr = p.pwr & ~f.unplug;
			if (cmd.power_off[i])
				p.pwr = 2'b00;
			if (p.st == ST_POWERED && p.pwr == 2'b00)
				p.st = ST_IDLE;

			// a mode change drops the port back to a clean start
			if (restart[i] || m == MODE_SHUT) begin
				p.st  = ST_IDLE;
				p.pwr = 2'b00;
				p.req = '0;
				p.cnt = '0;
			end
			// a new fault wins over a clear in the same cycle
			p.start_fault   = (r_r.port[i].start_fault && !sf_clr[i]) || sf_set;
			r_nxt.port[i]   = p;
		end

		if (r_r.soft_rst)
			r_nxt = TOP_RST;
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			r_r <= TOP_RST;
		else
			r_r <= r_nxt;
	end

endmodule

`default_nettype wire

// *** verif/psms_checker.sv ***
/*
 * Port-level assertions of the mode sequencer, watching port 0.
 * Assumes binding to psms_port_mode_sequencer and only its ports.
 */
`default_nettype none
module psms_checker
	import psms_pkg::*;
(
	// clock and reset
	input wire logic                                           clk,
	input wire logic                                           rstn,
	// bus answer
	input wire logic                                           hreadyout,
	input wire logic                                           hresp,
	// front end, power and limits
	input wire psms_pkg::psms_fe_req_t [psms_pkg::NPORTS-1:0] fe_req,
	input wire psms_pkg::psms_fe_rsp_t [psms_pkg::NPORTS-1:0] fe_rsp,
	input wire logic [2*psms_pkg::NPORTS-1:0]                 power_en,
	input wire psms_pkg::psms_lim_t [psms_pkg::NPORTS-1:0]    port_lim
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	a_fault_drop: assert property (fe_rsp[0].fault != 2'h0 |=>
		(power_en[1:0] & $past(fe_rsp[0].fault)) == 2'h0) else $error("fault left power on");
	a_force_pair: assert property (fe_req[0].meas_force2 |-> fe_req[0].meas_go)
		else $error("forced current outside a reading");
	a_second_read: assert property (fe_req[0].meas_go && fe_req[0].meas_force2 |->
		$past(fe_rsp[0].meas_done)) else $error("second reading without first");
	a_first_read: assert property (fe_req[0].meas_go && !fe_req[0].meas_force2 |->
		$past(fe_rsp[0].det_done)) else $error("check not after detection");
	a_class_cause: assert property (fe_req[0].cls_go |->
		$past(fe_rsp[0].det_done || fe_rsp[0].meas_done)) else $error("class without detection");
	a_equal_lim: assert property (!port_lim[0].disc_low |->
		port_lim[0].p2_hw == port_lim[0].p4_hw && port_lim[0].ilim == 2'h0)
		else $error("low-class limits differ");
	a_high_lim: assert property (port_lim[0].disc_low |-> port_lim[0].p4_hw >= 8'h5A
		&& port_lim[0].p2_hw < port_lim[0].p4_hw) else $error("high-class limits wrong");
	a_lim_load: assert property ($changed(port_lim[0]) && port_lim[0] != '0 |->
		$rose(power_en[0] | power_en[1])) else $error("limits loaded without power-up");
	c_power: cover property ($rose(power_en[0]));
	c_check: cover property (fe_req[0].meas_force2);
	c_split: cover property (port_lim[0].disc_low);
endmodule
bind psms_port_mode_sequencer psms_checker u_psms_checker (.clk(clk), .rstn(rstn),
	.hreadyout(hreadyout), .hresp(hresp), .fe_req(fe_req), .fe_rsp(fe_rsp),
	.power_en(power_en), .port_lim(port_lim));
`default_nettype wire

// *** verif/psms_fe_model.sv ***
/*
 * Measurement front end with an attached powered device, for all ports.
 * Assumes the bench sets the device inputs just after a rising edge.
 */
`default_nettype none
module psms_fe_model
	import psms_pkg::*;
(
	// clock and reset
	input  wire logic                                           clk,
	input  wire logic                                           rstn,
	// sequencer side
	input  wire psms_pkg::psms_fe_req_t [psms_pkg::NPORTS-1:0] fe_req,
	output var  psms_pkg::psms_fe_rsp_t [psms_pkg::NPORTS-1:0] fe_rsp,
	// attached device
	input  wire logic                                           pd_ok,
	input  wire logic                                           dual,
	input  wire logic                                           chg,
	input  wire logic [2:0]                                     lat,
	input  wire logic [3:0]                                     cls,
	input  wire logic [1:0]                                     flt,
	input  wire logic [1:0]                                     unp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0]  kd [NPORTS];
	logic [2:0]  ct [NPORTS];
	logic [11:0] pat;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pat <= 12'h000;
			fe_rsp <= '0;
			for (int i = 0; i < NPORTS; i++) begin
				kd[i] <= 3'h0;
				ct[i] <= 3'h0;
			end
		end else begin
			pat <= pat + 12'h3A7;
			for (int i = 0; i < NPORTS; i++) begin
				// idle result lines wander so a stale value is never mistaken for data
				fe_rsp[i] <= '0;
				fe_rsp[i].meas_cur <= pat;
				fe_rsp[i].cls_val <= pat[3:0];
				fe_rsp[i].det_valid <= pat[0];
				fe_rsp[i].fault <= flt;
				fe_rsp[i].unplug <= unp;
				fe_rsp[i].pd_change <= chg && kd[i][1];
				if (fe_req[i].det_go || fe_req[i].meas_go || fe_req[i].cls_go) begin
					kd[i] <= fe_req[i].det_go ? 3'h1 : fe_req[i].cls_go ? 3'h4 :
						fe_req[i].meas_force2 ? 3'h3 : 3'h2;
					ct[i] <= lat;
				end else if (kd[i] != 3'h0 && ct[i] != 3'h0) begin
					ct[i] <= ct[i] - 3'h1;
				end else if (kd[i] != 3'h0) begin
					kd[i] <= 3'h0;
					fe_rsp[i].det_done <= kd[i] == 3'h1;
					fe_rsp[i].det_valid <= pd_ok;
					fe_rsp[i].meas_done <= kd[i][1];
					// a single signature moves the second reading, the one taken with channel two forced
					fe_rsp[i].meas_cur <= !kd[i][0] ? 12'h100 : dual ? 12'h110 : 12'h200;
					fe_rsp[i].cls_done <= kd[i] == 3'h4;
					fe_rsp[i].cls_val <= cls;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
/*
 * Bench of the mode sequencer: AHB-Lite tasks and mode scenarios on port 0.
 * Assumes the checker is bound to the design; the front-end model is instantiated here.
 */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import psms_pkg::*;
	localparam int HOLD = 20;
	localparam logic [7:0] p2x [9] = '{8'h1F, 8'h08, 8'h0E, 8'h1F, 8'h3C, 8'h40, 8'h4F, 8'h5B, 8'h6C};
	localparam logic [7:0] p4x [9] = '{8'h1F, 8'h08, 8'h0E, 8'h1F, 8'h3C, 8'h5A, 8'h78, 8'h96, 8'hB4};
	localparam logic [1:0] ilx [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	logic        clk = 1'b0, rstn = 1'b0, strap = 1'b0, spare = 1'b0, hsel = 1'b0;
	logic        hwrite = 1'b0, pd_ok = 1'b0, dual = 1'b0, chg = 1'b0;
	logic [1:0]  htrans = 2'h0, flt = 2'h0, unp = 2'h0;
	logic [2:0]  hsize = 3'h2, lat = 3'h0;
	logic [3:0]  cls = 4'h3;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic        hready, hreadyout, hresp;
	logic [7:0]  power_en;
	psms_fe_req_t [NPORTS-1:0] fe_req;
	psms_fe_rsp_t [NPORTS-1:0] fe_rsp;
	psms_lim_t [NPORTS-1:0]    port_lim;
	int          fails = 0, total_checks = 0, cyc = 0, t_cls = 0;
	assign hready = hreadyout;
	psms_port_mode_sequencer #(.HOLD_CYC(HOLD)) u_psms_port_mode_sequencer (.clk(clk),
		.rstn(rstn), .mode_strap_pin(strap), .spare_strap_pin(spare), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fe_req(fe_req),
		.fe_rsp(fe_rsp), .power_en(power_en), .port_lim(port_lim));
	psms_fe_model u_psms_fe_model (.clk(clk), .rstn(rstn), .fe_req(fe_req), .fe_rsp(fe_rsp),
		.pd_ok(pd_ok), .dual(dual), .chg(chg), .lat(lat), .cls(cls), .flt(flt), .unp(unp));
	always #2 clk = ~clk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (fe_rsp[0].cls_done)
			t_cls <= cyc;
		if (cyc == 40000) begin
			fails++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int i;
		i = 0;
		do begin
			bus(1'b0, a, 32'h0);
			i++;
		end while ((q & m) !== e && i < 200);
		chk(q & m, e);
	endtask
	// fault or unplug held for one cycle, then the dropped channels are checked
	task automatic hit(input logic [1:0] f, input logic [1:0] u);
		@(posedge clk);
		flt <= f;
		unp <= u;
		@(posedge clk);
		flt <= 2'h0;
		unp <= 2'h0;
		repeat (2) @(posedge clk);
		chk({30'h0, power_en[1:0] & (f | u)}, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, OFS_MODE, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, OFS_ENABLE, 32'h1);
		bus(1'b1, OFS_CMD, 32'h111);
		repeat (10) @(posedge clk);
		bus(1'b0, OFS_STATUS0, 32'h0);
		chk(q | {24'h0, power_en}, 32'h0);
		$display("shutdown test over");
		bus(1'b1, OFS_MODE, 32'h1);
		bus(1'b1, OFS_CMD, 32'h100);
		poll(OFS_STATUS0, 32'hF00, 32'h800);
		bus(1'b1, OFS_STATUS0, 32'h800);
		pd_ok <= 1'b1;
		bus(1'b1, OFS_ENABLE, 32'h1011);
		bus(1'b1, OFS_CMD, 32'h10);
		poll(OFS_STATUS0, 32'h7FFF, 32'h0137);
		bus(1'b1, OFS_CMD, 32'h100);
		poll(OFS_STATUS0, 32'h7600, 32'h6600);
		chk({5'h0, port_lim[0], power_en}, 32'h3);
		bus(1'b1, OFS_CMD, 32'h1000);
		poll(OFS_STATUS0, 32'h600, 32'h0);
		$display("manual test over");
		bus(1'b1, OFS_ENABLE, 32'h11);
		bus(1'b1, OFS_MODE, 32'h2);
		poll(OFS_STATUS0, 32'h7000, 32'h5000);
		for (int i = 0; i < 100 && fe_req[0].det_go !== 1'b1; i++)
			@(posedge clk);
		chk({29'h0, fe_req[0].det_go, cyc - t_cls >= HOLD, power_en[0]}, 32'h6);
		bus(1'b1, OFS_CMD, 32'h100);
		poll(OFS_STATUS0, 32'h600, 32'h200);
		chk({5'h0, port_lim[0], power_en}, 32'h1);
		$display("semi-auto test over");
		bus(1'b1, OFS_ENABLE, 32'h111);
		bus(1'b1, OFS_MODE, 32'h3);
		@(posedge clk);
		chk({24'h0, power_en}, 32'h0);
		for (int c = 0; c < 9; c++) begin
			cls <= c[3:0];
			hit(2'h3, 2'h0);
			poll(OFS_STATUS0, 32'h7000, 32'h6000);
			chk({13'h0, port_lim[0]}, {13'h0, p2x[c], p4x[c], ilx[c], c > 4});
			chk({24'h0, power_en}, c > 4 ? 32'h3 : 32'h1);
		end
		hit(2'h0, 2'h1);
		bus(1'b1, OFS_ENABLE, 32'h1111);
		dual <= 1'b1;
		cls <= 4'h5;
		lat <= 3'h4;
		hit(2'h3, 2'h0);
		poll(OFS_STATUS0, 32'h700C, 32'h6008);
		chk({5'h0, port_lim[0], power_en}, {5'h0, 8'h5A, 8'hB4, 2'h3, 1'b1, 8'h3});
		chg <= 1'b1;
		hit(2'h3, 2'h0);
		poll(OFS_STATUS0, 32'hC, 32'hC);
		chk({24'h0, power_en}, 32'h0);
		chg <= 1'b0;
		dual <= 1'b0;
		bus(1'b1, OFS_ENABLE, 32'h11111);
		hit(2'h3, 2'h0);
		poll(OFS_STATUS0, 32'h700C, 32'h6004);
		chk({13'h0, port_lim[0]}, {13'h0, 8'h1F, 8'h1F, 2'h0, 1'b0});
		$display("auto test over");
		strap <= 1'b1;
		spare <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk(q, 32'h2);
		bus(1'b0, OFS_MODE, 32'h0);
		chk(q, 32'hFF);
		bus(1'b0, OFS_ENABLE, 32'h0);
		chk(q & 32'hFFF, 32'hFFF);
		poll(OFS_STATUS0, 32'h7000, 32'h6000);
		$display("strap test over");
		final_report();
	end
endmodule
`default_nettype wire
